// file: swd_top.sv
`timescale 1ns/1ps
module swd_top #(
  parameter int unsigned TO_LONG_CYC = swd_pkg::TO_LONG_CYC,
  parameter int unsigned TO_SHORT_CYC = swd_pkg::TO_SHORT_CYC,
  parameter int unsigned SETUP_CYC = swd_pkg::SETUP_CYC,
  parameter int unsigned EVAL_CYC = swd_pkg::EVAL_CYC,
  parameter int unsigned HOLD_CYC = swd_pkg::HOLD_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Supply and manual reset pins.
  input wire logic supply_valid,
  input wire logic manual_reset_n,
  // Watchdog pins.
  input wire logic watchdog_kick_in,
  input wire logic watchdog_enable_pin,
  input wire logic [1:0] timeout_config_pin,
  input wire logic cap_ramp_done,
  output logic cap_charge_en,
  // Open-drain reset output.
  output logic reset_n_o,
  output logic reset_n_oe,
  // Open-drain watchdog fault output.
  output logic watchdog_fault_n_o,
  output logic watchdog_fault_n_oe
);

  // Turns a cycle count into the saturation limit of a timer.
  function automatic logic [swd_pkg::TMR_W-1:0] cyc_lim(input int unsigned n);
    cyc_lim = swd_pkg::TMR_W'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  wire [swd_pkg::PIN_W-1:0] pin_raw = {cap_ramp_done, timeout_config_pin,
                                       watchdog_enable_pin, watchdog_kick_in,
                                       manual_reset_n, supply_valid};
  logic [swd_pkg::PIN_W-1:0] sync1_q;
  logic [swd_pkg::PIN_W-1:0] sync2_q;
  logic kick_prev_q;
  logic sv_prev_q;

  // Two stages on every pin; only the second stage feeds logic.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= swd_pkg::PIN_RST;
      sync2_q <= swd_pkg::PIN_RST;
      kick_prev_q <= 1'b0;
      sv_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      kick_prev_q <= sync2_q[swd_pkg::PIN_KICK];
      sv_prev_q <= sync2_q[swd_pkg::PIN_SV];
    end
  end

  wire sv_s = sync2_q[swd_pkg::PIN_SV];
  wire man_rst_s = sync2_q[swd_pkg::PIN_MANRST];
  wire kick_s = sync2_q[swd_pkg::PIN_KICK];
  wire en_s = sync2_q[swd_pkg::PIN_EN];
  wire ramp_s = sync2_q[swd_pkg::PIN_RAMP];
  wire [1:0] strap_s = sync2_q[swd_pkg::PIN_CFG_HI:swd_pkg::PIN_CFG_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Reset generation and strap evaluation.
  swd_tmr_if hold_if ();
  swd_tmr_if setup_if ();
  swd_tmr_if to_if ();
  swd_tmr_if flt_if ();
  logic cfg_valid;
  logic [1:0] cfg_mode;

  wire rst_req = !sv_s || !man_rst_s;
  wire reset_assert_d = rst_req || !hold_if.done;
  assign hold_if.clear = rst_req;
  assign hold_if.run = 1'b1;
  assign hold_if.limit = cyc_lim(HOLD_CYC);

  swd_timer u_hold (
    .mclk (mclk),
    .rst_b (rst_b),
    .t (hold_if)
  );

  // Evaluation restarts on every rising supply-valid edge.
  swd_cfg_eval u_cfg (
    .mclk (mclk),
    .rst_b (rst_b),
    .supply_ok (sv_s),
    .start (sv_s && !sv_prev_q),
    .strap (strap_s),
    .eval_lim (cyc_lim(EVAL_CYC)),
    .valid_q (cfg_valid),
    .mode_q (cfg_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog qualification, built from next-cycle reset so that the fault
  // output releases on the very edge that reset asserts.
  swd_pkg::swd_state_t state_q;
  swd_pkg::swd_state_t state_d;

  wire wd_active = !reset_assert_d && en_s && cfg_valid;
  wire is_cap = (cfg_mode == swd_pkg::STRAP_CAP);
  wire is_pullup = (cfg_mode == swd_pkg::STRAP_PULLUP);
  wire kick_fall = kick_prev_q && !kick_s;
  wire accepted = wd_active && setup_if.done && kick_fall;
  wire in_watch = (state_q == swd_pkg::SWD_WATCH);

  // Enable setup window; cleared whenever the watchdog is inactive.
  assign setup_if.clear = !wd_active;
  assign setup_if.run = 1'b1;
  assign setup_if.limit = cyc_lim(SETUP_CYC);

  swd_timer u_setup (
    .mclk (mclk),
    .rst_b (rst_b),
    .t (setup_if)
  );

  // Fixed timeouts count exactly the typical figure, well inside the tolerance.
  assign to_if.clear = !wd_active || !in_watch || accepted;
  assign to_if.run = 1'b1;
  assign to_if.limit = is_pullup ? cyc_lim(TO_SHORT_CYC) : cyc_lim(TO_LONG_CYC);

  swd_timer u_to (
    .mclk (mclk),
    .rst_b (rst_b),
    .t (to_if)
  );

  // The fault pulse lasts the reset hold period.
  assign flt_if.clear = !wd_active || in_watch;
  assign flt_if.run = 1'b1;
  assign flt_if.limit = cyc_lim(HOLD_CYC);

  swd_timer u_flt (
    .mclk (mclk),
    .rst_b (rst_b),
    .t (flt_if)
  );

  // With a capacitor the external ramp comparator marks the timeout instead.
  wire expired = is_cap ? (ramp_s && cap_charge_en) : to_if.done;

  ////////////////////////////////////////////////////////////////////////////
  // Supervision state machine.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      swd_pkg::SWD_WATCH:
      begin
        if (wd_active && !accepted && expired)
        begin
          state_d = swd_pkg::SWD_FAULT;
        end
      end
      swd_pkg::SWD_FAULT:
      begin
        if (!wd_active || flt_if.done)
        begin
          state_d = swd_pkg::SWD_WATCH;
        end
      end
      default:
      begin
        state_d = swd_pkg::SWD_WATCH;
      end
    endcase
  end

  // The capacitor is discharged on every restart so each period starts at 0 V.
  wire charge_d = wd_active && is_cap && (state_d == swd_pkg::SWD_WATCH) && !accepted;
  wire fault_oe_d = wd_active && (state_d == swd_pkg::SWD_FAULT);

  // Output and state registers; reset comes up asserted.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= swd_pkg::SWD_WATCH;
      reset_n_oe <= 1'b1;
      watchdog_fault_n_oe <= 1'b0;
      cap_charge_en <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      reset_n_oe <= reset_assert_d;
      watchdog_fault_n_oe <= fault_oe_d;
      cap_charge_en <= charge_d;
    end
  end

  // Both pins only ever pull low.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_n_o <= 1'b0;
      watchdog_fault_n_o <= 1'b0;
    end
    else
    begin
      reset_n_o <= 1'b0;
      watchdog_fault_n_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters for the pulse-length checks.
  logic [swd_pkg::TMR_W-1:0] flt_len_q;
  logic [swd_pkg::TMR_W-1:0] free_len_q;
  logic wd_active_q;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flt_len_q <= swd_pkg::TMR_ZERO;
      free_len_q <= swd_pkg::TMR_ZERO;
      wd_active_q <= 1'b0;
    end
    else
    begin
      flt_len_q <= watchdog_fault_n_oe ? flt_len_q + 32'h0000_0001 : swd_pkg::TMR_ZERO;
      free_len_q <= rst_req ? swd_pkg::TMR_ZERO : free_len_q + 32'h0000_0001;
      wd_active_q <= wd_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_FAULT_LEN: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(watchdog_fault_n_oe) && wd_active_q |-> flt_len_q == HOLD_CYC)
    else $error("Fault pulse length differs from the hold period.");

  AST_FAULT_OFF_IN_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
    reset_n_oe |-> !watchdog_fault_n_oe)
    else $error("Fault output driven while reset is asserted.");

  AST_DISABLED_QUIET: assert property (@(posedge mclk) disable iff (!rst_b)
    !en_s |=> !watchdog_fault_n_oe)
    else $error("Fault output driven while the watchdog is disabled.");

  AST_SETUP_IGNORE: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(wd_active) |-> !setup_if.done [*8])
    else $error("Kick accepted inside the enable setup window.");

  AST_TIMEOUT_FAULT: assert property (@(posedge mclk) disable iff (!rst_b)
    in_watch && wd_active && !is_cap && to_if.done && !accepted |=> watchdog_fault_n_oe)
    else $error("Timeout did not raise the fault output.");

  AST_SUPPLY_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
    !sv_s |=> reset_n_oe && !watchdog_fault_n_oe)
    else $error("Low supply did not hold reset with the fault output released.");

  AST_FALL_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
    accepted |-> $past(kick_s) && !kick_s)
    else $error("Kick accepted without a falling edge.");

  AST_CFG_EVAL: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(sv_s) |=> !cfg_valid [*8])
    else $error("Strap result used before evaluation finished.");

  AST_RESET_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(reset_n_oe) |-> free_len_q == HOLD_CYC)
    else $error("Reset released before the hold period.");

  AST_KICK_RESTART: assert property (@(posedge mclk) disable iff (!rst_b)
    accepted |=> to_if.cnt == swd_pkg::TMR_ZERO)
    else $error("Accepted kick did not restart the timeout.");

  AST_CLEAR_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
    !wd_active |=> to_if.cnt == swd_pkg::TMR_ZERO && flt_if.cnt == swd_pkg::TMR_ZERO)
    else $error("Timers not cleared while the watchdog is inactive.");

endmodule // swd_top

// file: swd_pkg.sv
package swd_pkg;

  // Core clock rate and the derived cycles per microsecond.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Nominal times, each in its own unit.
  localparam int unsigned TO_LONG_MS = 1600;
  localparam int unsigned TO_SHORT_MS = 200;
  localparam int unsigned SETUP_US = 150;
  localparam int unsigned EVAL_US = 381;
  // Reset hold period, also the fault pulse length; a plain default.
  localparam int unsigned HOLD_MS = 200;

  // Cycle counts derived from the times (all divide exactly at 50 MHz).
  localparam int unsigned TO_LONG_CYC = TO_LONG_MS * 1000 * CYC_PER_US;
  localparam int unsigned TO_SHORT_CYC = TO_SHORT_MS * 1000 * CYC_PER_US;
  localparam int unsigned SETUP_CYC = SETUP_US * CYC_PER_US;
  localparam int unsigned EVAL_CYC = EVAL_US * CYC_PER_US;
  localparam int unsigned HOLD_CYC = HOLD_MS * 1000 * CYC_PER_US;

  // Width of every timer in the block.
  localparam int unsigned TMR_W = 32;

  // Sensed strap codes of the timeout configuration pin.
  localparam logic [1:0] STRAP_UNCONN = 2'h0;
  localparam logic [1:0] STRAP_PULLUP = 2'h1;
  localparam logic [1:0] STRAP_CAP = 2'h2;

  // Bit positions of the pin inputs inside the synchroniser vector.
  localparam int unsigned PIN_SV = 0;
  localparam int unsigned PIN_MANRST = 1;
  localparam int unsigned PIN_KICK = 2;
  localparam int unsigned PIN_EN = 3;
  localparam int unsigned PIN_CFG_LO = 4;
  localparam int unsigned PIN_CFG_HI = 5;
  localparam int unsigned PIN_RAMP = 6;
  localparam int unsigned PIN_W = 7;

  // Reset values.
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h00;

  // Watchdog supervision states.
  typedef enum logic [0:0] {
    SWD_WATCH,
    SWD_FAULT
  } swd_state_t;

endpackage

// file: swd_tmr_if.sv
`timescale 1ns/1ps
interface swd_tmr_if;
  logic clear;
  logic run;
  logic [swd_pkg::TMR_W-1:0] limit;
  logic [swd_pkg::TMR_W-1:0] cnt;
  logic done;

  modport ctl (output clear, output run, output limit, input cnt, input done);
  modport tmr (input clear, input run, input limit, output cnt, output done);
endinterface

// file: swd_timer.sv
`timescale 1ns/1ps
module swd_timer (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Control and count.
  swd_tmr_if.tmr t
);

  logic [swd_pkg::TMR_W-1:0] cnt_q;
  logic [swd_pkg::TMR_W-1:0] cnt_d;
  wire at_limit = (cnt_q == t.limit);

  ////////////////////////////////////////////////////////////////////////////
  // The count saturates at the limit so a late restart never wraps to zero.
  assign cnt_d = t.clear ? swd_pkg::TMR_ZERO :
                 (t.run && !at_limit) ? cnt_q + 32'h0000_0001 : cnt_q;
  assign t.cnt = cnt_q;
  assign t.done = at_limit && !t.clear;

  // Count register.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= swd_pkg::TMR_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule // swd_timer

// file: swd_cfg_eval.sv
`timescale 1ns/1ps
module swd_cfg_eval (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Supply qualification.
  input wire logic supply_ok,
  input wire logic start,
  // Sensed strap and evaluation length.
  input wire logic [1:0] strap,
  input wire logic [swd_pkg::TMR_W-1:0] eval_lim,
  // Result.
  output logic valid_q,
  output logic [1:0] mode_q
);

  logic [swd_pkg::TMR_W-1:0] cnt_q;
  logic busy_q;
  wire finish = busy_q && (cnt_q == eval_lim);

  ////////////////////////////////////////////////////////////////////////////
  // A fresh valid supply restarts the evaluation and withdraws the old result,
  // so a strap changed during a brown-out is always picked up.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      cnt_q <= swd_pkg::TMR_ZERO;
      mode_q <= swd_pkg::STRAP_UNCONN;
    end
    else if (!supply_ok || start)
    begin
      busy_q <= supply_ok;
      valid_q <= 1'b0;
      cnt_q <= swd_pkg::TMR_ZERO;
    end
    else if (finish)
    begin
      busy_q <= 1'b0;
      valid_q <= 1'b1;
      mode_q <= strap;
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

endmodule // swd_cfg_eval

// file: swd_host_model.sv
`timescale 1ns/1ps
// Host processor stand-in that services the watchdog kick pin.
module swd_host_model (
  // Clock.
  input wire logic mclk,
  // Control from the bench.
  input wire logic run,
  input wire logic [7:0] period,
  // Kick pin, driven by the host at all times.
  output logic kick
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] per_q = 8'h10;
  logic kick_q = 1'b1;
  wire wrap = (cnt_q >= per_q);

  ////////////////////////////////////////////////////////////////////////////////
  // The pin is held low for three cycles so each level is wider than the synchroniser.
  // A new period is taken only at a wrap or while stopped, so a change never cuts a level short.
  always @(posedge mclk)
  begin
    if (!run)
    begin
      cnt_q <= 8'h00;
      per_q <= period;
      kick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      per_q <= wrap ? period : per_q;
      kick_q <= !(cnt_q >= per_q - 8'h02);
    end
  end

  assign kick = kick_q;
endmodule // swd_host_model

// file: swd_top_tb.sv
`timescale 1ns/1ps
module swd_top_tb;
  localparam int TO_L = 400;
  localparam int TO_S = 100;
  localparam int SET = 40;
  localparam int EVL = 30;
  localparam int HLD = 50;
  localparam int CAP = 40;
  localparam int LIMIT = 20000;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic sv = 1'b1;
  logic man_rst = 1'b1;
  logic en = 1'b1;
  logic [1:0] strap = 2'h0;
  logic ramp = 1'b0;
  logic run = 1'b0;
  logic [7:0] period = 8'h10;
  logic kick;
  logic charge;
  logic rst_o;
  logic rst_oe;
  logic wdf_o;
  logic wdf_oe;
  int ramp_cnt = 0;
  int fail_count = 0;
  int check_count = 0;
  int seed = 55644;
  int cyc = 0;
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  swd_host_model host (.mclk(mclk), .run(run), .period(period), .kick(kick));

  swd_top #(.TO_LONG_CYC(TO_L), .TO_SHORT_CYC(TO_S), .SETUP_CYC(SET), .EVAL_CYC(EVL),
    .HOLD_CYC(HLD)) uut (
    .mclk(mclk),
    .rst_b(rst_b),
    .supply_valid(sv),
    .manual_reset_n(man_rst),
    .watchdog_kick_in(kick),
    .watchdog_enable_pin(en),
    .timeout_config_pin(strap),
    .cap_ramp_done(ramp),
    .cap_charge_en(charge),
    .reset_n_o(rst_o),
    .reset_n_oe(rst_oe),
    .watchdog_fault_n_o(wdf_o),
    .watchdog_fault_n_oe(wdf_oe)
  );

  initial forever #10 mclk = ~mclk;

  // Capacitor stand-in: the ramp trips CAP cycles after charging starts.
  always @(negedge mclk)
  begin
    ramp_cnt <= charge ? ramp_cnt + 1 : 0;
    ramp <= (ramp_cnt >= CAP);
  end

  // A hung run is cut short and counted as a mismatch.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      $display("MISMATCH run_cycles expected below %0d seen %0d", LIMIT, cyc);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_range(string name, int lo, int hi, int got);
    check_count++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic end_test(string name);
    $display("test %s done", name);
  endtask

  // Counts falling edges until the chosen output reaches lvl, giving up at max.
  task automatic wait_sig(bit fault, logic lvl, int max, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge mclk);
      cnt++;
    end
    while (((fault ? wdf_oe : rst_oe) !== lvl) && cnt < max);
  endtask

  // Typical timeout for a strap code; the capacitor figure adds pin latency.
  function automatic int nom(logic [1:0] s);
    return (s == 2'h1) ? TO_S : (s == 2'h2) ? CAP + 8 : TO_L;
  endfunction

  task automatic check_to(string name, logic [1:0] s);
    wait_sig(1'b1, 1'b1, 2 * TO_L, n);
    check_range(name, nom(s) * 85 / 100, nom(s) * 115 / 100, n);
  endtask

  // Dropping the supply forces a new strap evaluation on its return.
  task automatic supply_cycle(logic [1:0] s);
    sv = 1'b0;
    repeat (5) @(negedge mclk);
    check_bit("reset_oe", 1'b1, rst_oe);
    check_bit("fault_oe", 1'b0, wdf_oe);
    check_bit("reset_o", 1'b0, rst_o);
    check_bit("fault_o", 1'b0, wdf_o);
    strap = s;
    sv = 1'b1;
    wait_sig(1'b0, 1'b0, 2 * HLD, n);
    check_range("reset_hold", HLD, HLD + 8, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge mclk);
    check_bit("reset_oe", 1'b1, rst_oe);
    check_bit("fault_oe", 1'b0, wdf_oe);
    rst_b = 1'b1;
    wait_sig(1'b0, 1'b0, 2 * HLD, n);
    check_range("reset_hold", HLD, HLD + 8, n);
    check_to("long_timeout", 2'h0);
    wait_sig(1'b1, 1'b0, 2 * HLD, n);
    check_range("fault_pulse", HLD, HLD, n);
    check_to("restart", 2'h0);
    end_test("power_up");
    supply_cycle(2'h1);
    check_to("short_timeout", 2'h1);
    wait_sig(1'b1, 1'b0, 2 * HLD, n);
    end_test("pulled_up");
    repeat (8)
    begin
      period = 8'h04 + 8'($unsigned($random(seed)) % 32'h4c);
      run = 1'b1;
      wait_sig(1'b1, 1'b1, 300, n);
      check_range("kicked_no_fault", 300, 300, n);
    end
    run = 1'b0;
    end_test("random_kicks");
    period = 8'h1e;
    en = 1'b0;
    repeat (4) @(negedge mclk);
    check_bit("fault_oe", 1'b0, wdf_oe);
    wait_sig(1'b1, 1'b1, 3 * TO_S, n);
    check_range("disabled_no_fault", 3 * TO_S, 3 * TO_S, n);
    run = 1'b1;
    en = 1'b1;
    repeat (32) @(negedge mclk);
    run = 1'b0;
    wait_sig(1'b1, 1'b1, 2 * TO_S, n);
    check_range("setup_kick_ignored", TO_S * 85 / 100 - 32, TO_S * 115 / 100 - 32, n);
    end_test("enable");
    repeat (5) @(negedge mclk);
    man_rst = 1'b0;
    repeat (5) @(negedge mclk);
    check_bit("fault_oe", 1'b0, wdf_oe);
    check_bit("reset_oe", 1'b1, rst_oe);
    man_rst = 1'b1;
    wait_sig(1'b0, 1'b0, 2 * HLD, n);
    check_range("manual_hold", HLD, HLD + 8, n);
    check_to("resume", 2'h1);
    wait_sig(1'b1, 1'b0, 2 * HLD, n);
    end_test("manual_reset");
    supply_cycle(2'h2);
    check_to("cap_timeout", 2'h2);
    check_bit("charge", 1'b0, charge);
    wait_sig(1'b1, 1'b0, 2 * HLD, n);
    check_range("cap_fault_pulse", HLD, HLD, n);
    check_bit("charge", 1'b1, charge);
    check_to("cap_restart", 2'h2);
    end_test("capacitor");
    wrap_up();
  end
endmodule // swd_top_tb
